// ===== verilog/peci_timing_pkg.sv
// Constants and types for the single-wire originator bit timing engine
// Overview of operation
// - Link bit period 0.495 to 500 us; originator drives 0.495 to 250 us.
// - Adjacent bit periods within a message differ by about one percent.
// - Bit period drift across address and message bits stays near two percent.
// - A one holds the line high 0.6 to 0.8 of the period, nominal 0.75.
// - A zero holds the line high 0.2 to 0.4 of the period, nominal 0.3.
// - The originator ends a message with constant low for two bit periods.
// - Two bit periods without a rising edge mark the message end for both.
// - The low time before a message may overlap the previous stop time.
// - Cell timings are relative to the period negotiated at message start.
// - Driven period is tighter than the link limit to absorb client sampling.
package peci_timing_pkg;

   // Clock rate
   localparam real CLK_MHZ         = 50.0;

   // Times in their printed units
   localparam real BIT_MIN_US      = 0.495;
   localparam real BIT_MAX_DRV_US  = 250.0;
   localparam real SETUP_UNK_MS    = 1.0;
   localparam real CLIENT_RESET_MS = 0.4;

   // Cycle counts derived from the clock rate
   localparam int BIT_MIN_CYC      = int'($ceil(BIT_MIN_US * CLK_MHZ));
   localparam int BIT_MAX_CYC_DEF  = int'($floor(BIT_MAX_DRV_US * CLK_MHZ));
   localparam int SETUP_UNK_CYC    = int'($ceil(SETUP_UNK_MS * 1000.0
                                                * CLK_MHZ));
   localparam int CLIENT_RESET_CYC = int'($floor(CLIENT_RESET_MS * 1000.0
                                                 * CLK_MHZ));

   // Widths
   localparam int PER_W            = 16;
   localparam int CNT_W            = 17;
   localparam int SYM_W            = 2;

   // Symbol fields: bit value and last-bit marker
   localparam int SYM_BIT          = 0;
   localparam int SYM_LAST         = 1;

   // High-time ratios: one = 3/4 period, zero = 77/256 period
   localparam int ONE_MUL          = 3;
   localparam int ONE_SHIFT        = 2;
   localparam int ZERO_MUL         = 77;
   localparam int ZERO_SHIFT       = 8;

   // Cell states, Gray coded along idle, high, low, stop
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_HIGH = 2'h1,
      ST_LOW  = 2'h3,
      ST_STOP = 2'h2
   } cell_state_t;

   // High part of a cell in clock cycles
   function automatic logic [PER_W-1:0] high_time(
      input logic             bit_val,
      input logic [PER_W-1:0] per
   );
      logic [PER_W+7:0] prod;
      prod = '0;
      if (bit_val) begin
         prod = ({8'h00, per} * (PER_W+8)'(ONE_MUL)) >> ONE_SHIFT;
      end else begin
         prod = ({8'h00, per} * (PER_W+8)'(ZERO_MUL)) >> ZERO_SHIFT;
      end
      return prod[PER_W-1:0];
   endfunction

endpackage : peci_timing_pkg

// ===== verilog/sym_stream_if.sv
// Valid/ready stream carrying bit symbols between internal modules
interface sym_stream_if #(parameter int W = 2);
   logic [W-1:0] data;
   logic         valid;
   logic         ready;

   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface : sym_stream_if

// ===== verilog/sym_buffer.sv
// Two-entry valid/ready buffer for bit symbols
module sym_buffer
   import peci_timing_pkg::*;
(
   // Clock and reset
   input  wire logic     clock,
   input  wire logic     rst,
   // Filling side
   sym_stream_if.snk     fill,
   // Draining side
   sym_stream_if.src     drain
);

   logic [SYM_W-1:0] mem_reg [2];
   logic [SYM_W-1:0] mem_next [2];
   logic             wr_ptr_reg;
   logic             wr_ptr_next;
   logic             rd_ptr_reg;
   logic             rd_ptr_next;
   logic [1:0]       count_reg;
   logic [1:0]       count_next;
   logic             ready_reg;
   logic             ready_next;
   logic             push;
   logic             pull;

   assign fill.ready  = ready_reg;
   assign drain.valid = (count_reg != 2'h0);
   assign drain.data  = mem_reg[rd_ptr_reg];

   always_comb begin
      push        = fill.valid && ready_reg;
      pull        = drain.valid && drain.ready;
      mem_next    = mem_reg;
      wr_ptr_next = wr_ptr_reg;
      rd_ptr_next = rd_ptr_reg;
      count_next  = count_reg;
      if (push) begin
         mem_next[wr_ptr_reg] = fill.data;
         wr_ptr_next          = ~wr_ptr_reg;
      end
      if (pull) begin
         rd_ptr_next = ~rd_ptr_reg;
      end
      if (push && !pull) begin
         count_next = count_reg + 2'h1;
      end else if (pull && !push) begin
         count_next = count_reg - 2'h1;
      end
      // Ready is registered, so it looks at the next fill level
      ready_next = (count_next != 2'h2);
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         mem_reg[0] <= '0;
         mem_reg[1] <= '0;
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         count_reg  <= 2'h0;
         ready_reg  <= 1'b0;
      end else begin
         mem_reg    <= mem_next;
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
         count_reg  <= count_next;
         ready_reg  <= ready_next;
      end
   end

endmodule // sym_buffer

// ===== verilog/peci_originator_bit_timing.sv
// Originator bit-cell timing engine for the single-wire link
module peci_originator_bit_timing
   import peci_timing_pkg::*;
#(
   parameter logic [PER_W-1:0] BIT_MAX_CYC = 16'(BIT_MAX_CYC_DEF),
   parameter logic [PER_W-1:0] SETUP_CYC   = 16'(SETUP_UNK_CYC)
)
(
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             rst,
   // Bit symbols to send
   input  wire logic             bit_data,
   input  wire logic             bit_last,
   input  wire logic             bit_valid,
   output wire logic             bit_ready,
   // Requested bit period in clock cycles
   input  wire logic [PER_W-1:0] period_cycles,
   // Link pin
   input  wire logic             peci_in,
   output wire logic             peci_out,
   output wire logic             peci_oe_n,
   // Status
   output wire logic             busy,
   output wire logic             msg_end
);

   sym_stream_if #(.W(SYM_W)) in_if ();
   sym_stream_if #(.W(SYM_W)) out_if ();

   assign in_if.data  = {bit_last, bit_data};
   assign in_if.valid = bit_valid;
   assign bit_ready   = in_if.ready;

   sym_buffer u_buf (
      .clock (clock),
      .rst   (rst),
      .fill  (in_if),
      .drain (out_if)
   );

   cell_state_t      state_reg,   state_next;
   logic [CNT_W-1:0] cnt_reg,     cnt_next;
   logic [PER_W-1:0] period_reg,  period_next;
   logic [PER_W-1:0] prev_reg,    prev_next;
   logic             known_reg,   known_next;
   logic             bit_reg,     bit_next;
   logic             last_reg,    last_next;
   logic [CNT_W-1:0] low_cnt_reg, low_cnt_next;
   logic             out_reg,     out_next;
   logic             busy_reg,    busy_next;
   logic [PER_W-1:0] clamped;
   logic [CNT_W-1:0] setup_need;
   logic [CNT_W-1:0] stop_len;
   logic [CNT_W-1:0] hi_len;
   logic             pop;

   assign out_if.ready = pop;
   assign peci_out     = out_reg;
   assign peci_oe_n    = 1'b0;
   assign busy         = busy_reg;

   always_comb begin
      // Driven period kept inside the originator limits
      if (period_cycles < PER_W'(BIT_MIN_CYC)) begin
         clamped = PER_W'(BIT_MIN_CYC);
      end else if (period_cycles > BIT_MAX_CYC) begin
         clamped = BIT_MAX_CYC;
      end else begin
         clamped = period_cycles;
      end
      // Twice the previous period when known, else the long default
      setup_need = known_reg ? {prev_reg, 1'b0} : {1'b0, SETUP_CYC};
      stop_len   = {period_reg, 1'b0};
      hi_len     = {1'b0, high_time(bit_reg, period_reg)};
   end

   always_comb begin
      state_next  = state_reg;
      cnt_next    = cnt_reg;
      period_next = period_reg;
      prev_next   = prev_reg;
      known_next  = known_reg;
      bit_next    = bit_reg;
      last_next   = last_reg;
      pop         = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            // Low time since the last cell counts, stop included
            if (out_if.valid && low_cnt_reg >= setup_need) begin
               period_next = clamped;
               bit_next    = out_if.data[SYM_BIT];
               last_next   = out_if.data[SYM_LAST];
               pop         = 1'b1;
               cnt_next    = '0;
               state_next  = ST_HIGH;
            end
         end
         ST_HIGH: begin
            cnt_next = cnt_reg + 1'b1;
            if (cnt_reg >= hi_len - 1'b1) begin
               state_next = ST_LOW;
            end
         end
         ST_LOW: begin
            cnt_next = cnt_reg + 1'b1;
            if (cnt_reg >= {1'b0, period_reg} - 1'b1) begin
               // Period held for the whole message
               cnt_next = '0;
               if (last_reg) begin
                  state_next = ST_STOP;
               end else if (out_if.valid) begin
                  bit_next   = out_if.data[SYM_BIT];
                  last_next  = out_if.data[SYM_LAST];
                  pop        = 1'b1;
                  state_next = ST_HIGH;
               end else begin
                  // Underrun: cell stretches until a symbol arrives
                  cnt_next = cnt_reg;
               end
            end
         end
         ST_STOP: begin
            cnt_next = cnt_reg + 1'b1;
            if (cnt_reg >= stop_len - 1'b1) begin
               cnt_next   = '0;
               prev_next  = period_reg;
               known_next = 1'b1;
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
            cnt_next   = '0;
         end
      endcase
      out_next     = (state_next == ST_HIGH);
      busy_next    = (state_next != ST_IDLE);
      low_cnt_next = out_reg ? '0 :
                     (&low_cnt_reg ? low_cnt_reg : low_cnt_reg + 1'b1);
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state_reg   <= ST_IDLE;
         cnt_reg     <= '0;
         period_reg  <= PER_W'(BIT_MIN_CYC);
         prev_reg    <= '0;
         known_reg   <= 1'b0;
         bit_reg     <= 1'b0;
         last_reg    <= 1'b0;
         low_cnt_reg <= '0;
         out_reg     <= 1'b0;
         busy_reg    <= 1'b0;
      end else begin
         state_reg   <= state_next;
         cnt_reg     <= cnt_next;
         period_reg  <= period_next;
         prev_reg    <= prev_next;
         known_reg   <= known_next;
         bit_reg     <= bit_next;
         last_reg    <= last_next;
         low_cnt_reg <= low_cnt_next;
         out_reg     <= out_next;
         busy_reg    <= busy_next;
      end
   end

   // Message-end monitor on the wire as seen through a synchroniser
   logic             s1_reg,   s1_next;
   logic             s2_reg,   s2_next;
   logic             s3_reg,   s3_next;
   logic [CNT_W-1:0] rise_reg, rise_next;
   logic             end_reg,  end_next;

   assign msg_end = end_reg;

   always_comb begin
      s1_next   = peci_in;
      s2_next   = s1_reg;
      s3_next   = s2_reg;
      rise_next = &rise_reg ? rise_reg : rise_reg + 1'b1;
      end_next  = 1'b0;
      if (s2_reg && !s3_reg) begin
         rise_next = '0;
      end else if (rise_reg == stop_len - 1'b1) begin
         end_next = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         s1_reg   <= 1'b0;
         s2_reg   <= 1'b0;
         s3_reg   <= 1'b0;
         rise_reg <= '1;
         end_reg  <= 1'b0;
      end else begin
         s1_reg   <= s1_next;
         s2_reg   <= s2_next;
         s3_reg   <= s3_next;
         rise_reg <= rise_next;
         end_reg  <= end_next;
      end
   end

   // Helper: length of the current high pulse
   logic [CNT_W-1:0] hlen_reg, hlen_next;

   always_comb begin
      hlen_next = out_reg ? hlen_reg + 1'b1 : '0;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         hlen_reg <= '0;
      end else begin
         hlen_reg <= hlen_next;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   period_range_a: assert property (
      busy_reg |-> (int'(period_reg) >= BIT_MIN_CYC
                    && period_reg <= BIT_MAX_CYC))
      else $error("driven bit period out of range");

   period_stable_a: assert property (
      (state_reg != ST_IDLE && $past(state_reg) != ST_IDLE)
      |-> $stable(period_reg))
      else $error("bit period changed inside a message");

   one_high_a: assert property (
      ($fell(out_reg) && bit_reg) |->
      (int'(hlen_reg) * 10 >= int'(period_reg) * 6
       && int'(hlen_reg) * 10 <= int'(period_reg) * 8))
      else $error("one cell high time out of ratio");

   zero_high_a: assert property (
      ($fell(out_reg) && !bit_reg) |->
      (int'(hlen_reg) * 10 >= int'(period_reg) * 2
       && int'(hlen_reg) * 10 <= int'(period_reg) * 4))
      else $error("zero cell high time out of ratio");

   stop_low_a: assert property (
      (state_reg == ST_STOP && !out_reg) ##1 (state_reg == ST_IDLE)
      |-> $past(cnt_reg) == $past(stop_len) - 1'b1)
      else $error("stop low time wrong");

   setup_low_a: assert property (
      ($rose(out_reg) && $past(state_reg) == ST_IDLE)
      |-> $past(low_cnt_reg) >= $past(setup_need))
      else $error("message started without enough low time");

   end_detect_a: assert property (
      end_reg |-> $past(rise_reg) == $past(stop_len) - 1'b1)
      else $error("message end flagged at wrong time");

   cell_edge_a: assert property (
      $rose(out_reg) |-> (state_reg == ST_HIGH && cnt_reg == '0))
      else $error("cell did not start with a rising edge");

   one_msg_c:   cover property ($rose(state_reg == ST_STOP));
   zero_bit_c:  cover property ($fell(out_reg) && !bit_reg);
   back_back_c: cover property ($fell(busy_reg) ##[1:1000] $rose(busy_reg));
   end_seen_c:  cover property (end_reg);

endmodule // peci_originator_bit_timing

// ===== verif/peci_client_model.sv
// Behavioural client on the shared wire that answers bit cells with ones
module peci_client_model (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       rst,
   // Answer control
   input  wire logic       resp_en,
   input  wire logic [7:0] delay_cyc,
   input  wire logic [7:0] hold_cyc,
   // Wire
   input  wire logic       wire_in,
   output logic            drive_hi
);
   timeunit 1ns;
   timeprecision 1ns;

   logic       prev_reg;
   logic       act_reg;
   logic [7:0] cnt_reg;

   // Never drives low, so no idle drive outlives a message start
   always_ff @(posedge clock) begin
      prev_reg <= wire_in;
      if (rst) begin
         act_reg  <= 1'b0;
         cnt_reg  <= 8'h00;
         drive_hi <= 1'b0;
      end else if (wire_in && !prev_reg && resp_en && !act_reg) begin
         act_reg <= 1'b1;
         cnt_reg <= 8'h00;
      end else if (act_reg) begin
         cnt_reg  <= cnt_reg + 8'h01;
         drive_hi <= (cnt_reg >= delay_cyc) && (cnt_reg < hold_cyc);
         if (cnt_reg == hold_cyc) begin
            act_reg <= 1'b0;
         end
      end
   end
endmodule // peci_client_model

// ===== verif/peci_originator_bit_timing_test.sv
// Self-checking bench for the originator bit timing engine
module peci_originator_bit_timing_test;
   timeunit 1ns;
   timeprecision 1ns;

   logic        clock;
   logic        rst;
   logic        bit_data;
   logic        bit_last;
   logic        bit_valid;
   logic        bit_ready;
   logic [15:0] period_cycles;
   logic        peci_in;
   logic        peci_out;
   logic        peci_oe_n;
   logic        busy;
   logic        msg_end;
   logic        resp_en;
   logic        client_hi;
   int          num_errors;
   int          total_checks;
   int          cyc;
   int          rel;
   int          idle_cyc;
   int          end_cyc;
   int          last_fall;
   int          rise_q[$];
   int          high_q[$];
   logic        prev_out;
   logic        prev_busy;
   logic        refused;

   // Wire level: our drive plus the client's high drive, low when idle
   assign peci_in = (peci_out & ~peci_oe_n) | client_hi;

   peci_originator_bit_timing #(
      .BIT_MAX_CYC (16'h0064),
      .SETUP_CYC   (16'h003c)
   ) dut (
      .clock         (clock),
      .rst           (rst),
      .bit_data      (bit_data),
      .bit_last      (bit_last),
      .bit_valid     (bit_valid),
      .bit_ready     (bit_ready),
      .period_cycles (period_cycles),
      .peci_in       (peci_in),
      .peci_out      (peci_out),
      .peci_oe_n     (peci_oe_n),
      .busy          (busy),
      .msg_end       (msg_end)
   );

   peci_client_model client (
      .clock     (clock),
      .rst       (rst),
      .resp_en   (resp_en),
      .delay_cyc (8'h10),
      .hold_cyc  (8'h4b),
      .wire_in   (peci_in),
      .drive_hi  (client_hi)
   );

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   // Cell monitor, sampled where outputs are settled
   always @(negedge clock) begin
      cyc <= cyc + 1;
      prev_out <= peci_out;
      prev_busy <= busy;
      if (peci_out === 1'b1 && prev_out === 1'b0) begin
         rise_q.push_back(cyc);
      end
      if (peci_out === 1'b0 && prev_out === 1'b1) begin
         high_q.push_back(cyc - rise_q[$]);
         last_fall <= cyc;
      end
      if (prev_busy === 1'b1 && busy === 1'b0) begin
         idle_cyc <= cyc;
      end
      if (msg_end === 1'b1) begin
         end_cyc <= cyc;
      end
      if (bit_valid && bit_ready === 1'b0) begin
         refused <= 1'b1;
      end
   end

   task automatic check_num(input string nm, input int lo, input int hi,
                            input int got);
      total_checks++;
      if (got < lo || got > hi) begin
         num_errors++;
         $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
      end
   endtask

   task automatic check_bit(input string nm, input logic exp,
                            input logic got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %b seen %b", nm, exp, got);
      end
   endtask

   function automatic int exp_high(input logic b, input int p);
      return b ? (3 * p) / 4 : (77 * p) / 256;
   endfunction

   task automatic send(input logic [15:0] per, input int n,
                       input logic [7:0] bits);
      int w;
      period_cycles = per;
      for (int k = 0; k < n; k++) begin
         bit_data = bits[k];
         bit_last = logic'(k == n - 1);
         bit_valid = 1'b1;
         for (w = 0; w < 5000 && bit_ready !== 1'b1; w++) @(negedge clock);
         @(negedge clock);
      end
      bit_valid = 1'b0;
   endtask

   task automatic done(input int n);
      int w;
      for (w = 0; w < 9000 && rise_q.size() < n; w++) @(negedge clock);
      for (w = 0; w < 9000 && busy !== 1'b0; w++) @(negedge clock);
      repeat (2) @(negedge clock);
   endtask

   // Cells, periods, stop and end detection; brk marks a message seam
   task automatic verify(input int p, input int n, input logic [7:0] bits,
                         input int brk);
      int last;
      done(n);
      check_num("cells", n, n, rise_q.size());
      if (rise_q.size() != n) return;
      for (int k = 0; k < n; k++) begin
         check_num("high", exp_high(bits[k], p), exp_high(bits[k], p),
                   high_q[k]);
         if (k > 0 && k == brk) begin
            check_num("seam", 3 * p, 3 * p + 3, rise_q[k] - rise_q[k-1]);
         end else if (k > 0) begin
            check_num("period", p, p, rise_q[k] - rise_q[k-1]);
         end
      end
      last = rise_q[n-1];
      check_num("stop", 3 * p, 3 * p, idle_cyc - last);
      check_num("end", 2 * p, 2 * p + 4, end_cyc - last);
      check_bit("oe_n", 1'b0, peci_oe_n);
      rise_q.delete();
      high_q.delete();
   endtask

   // Period known from the last message: low time before start >= 2P
   task automatic t_first;
      int lo;
      lo = last_fall;
      send(16'h0028, 5, 8'h0d);
      done(5);
      check_num("setup", 80, 130, rise_q[0] - lo);
      verify(40, 5, 8'h0d, 0);
   endtask

   // Period unknown after reset: the long setup count applies
   task automatic t_unknown;
      rel = cyc;
      send(16'h0028, 1, 8'h01);
      done(1);
      check_num("setup", 60, 66, rise_q[0] - rel);
      verify(40, 1, 8'h01, 0);
   endtask

   task automatic t_clamp;
      send(16'h000a, 2, 8'h02);
      verify(25, 2, 8'h02, 0);
      send(16'h00c8, 3, 8'h05);
      period_cycles = 16'h0019;
      verify(100, 3, 8'h05, 0);
   endtask

   task automatic t_b2b;
      send(16'h001e, 2, 8'h01);
      // Let an edge pass so valid is not lowered and raised at once
      @(negedge clock);
      send(16'h001e, 3, 8'h06);
      verify(30, 5, 8'h19, 2);
   endtask

   task automatic t_buffer;
      resp_en = 1'b1;
      refused = 1'b0;
      send(16'h0064, 6, 8'h2a);
      check_bit("refused", 1'b1, refused);
      verify(100, 6, 8'h2a, 0);
      resp_en = 1'b0;
   endtask

   task automatic close_out;
      $display("Checks %0d, errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clock);
      num_errors++;
      close_out;
   end

   initial begin
      rst = 1'b1;
      bit_data = 1'b0;
      bit_last = 1'b0;
      bit_valid = 1'b0;
      period_cycles = 16'h0028;
      resp_en = 1'b0;
      num_errors = 0;
      total_checks = 0;
      cyc = 0;
      repeat (10) @(negedge clock);
      check_bit("rst_out", 1'b0, peci_out);
      check_bit("rst_oe_n", 1'b0, peci_oe_n);
      check_bit("rst_busy", 1'b0, busy);
      check_bit("rst_end", 1'b0, msg_end);
      check_bit("rst_ready", 1'b0, bit_ready);
      rst = 1'b0;
      t_unknown;
      t_first;
      t_clamp;
      t_b2b;
      t_buffer;
      close_out;
   end
endmodule // peci_originator_bit_timing_test
